// ===== hw/sps_pkg.sv
// constants, register map and state types for the serial peripheral port
package sps_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CONTROL  = 8'h0A;
   localparam logic [7:0] IDX_STATUS   = 8'h0B;
   localparam logic [7:0] IDX_DATA     = 8'h0C;
   localparam logic [9:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
   localparam logic [9:0] ADDR_STATUS  = {IDX_STATUS, 2'b00};
   localparam logic [9:0] ADDR_DATA    = {IDX_DATA, 2'b00};

   // control register fields
   localparam int CTL_IRQ_EN   = 7;
   localparam int CTL_PORT_EN  = 6;
   localparam int CTL_CSEL     = 4;
   localparam int CTL_IDLE_CLOCK_LEVEL     = 3;
   localparam int CTL_CLOCK_PHASE_SELECT     = 2;
   localparam int CTL_RATE_HI  = 1;
   localparam int CTL_RATE_LO  = 0;

   // status register fields
   localparam int STS_DONE     = 7;
   localparam int STS_WRITE_COLLISION_FLAG     = 6;
   localparam int STS_MODE_FAULT_FLAG     = 4;

   // master clock divide ratios per rate select code
   localparam int DIV_R00      = 2;
   localparam int DIV_R01      = 4;
   localparam int DIV_R10      = 16;
   localparam int DIV_R11      = 32;

   // shift length and the last of its sixteen clock edges
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [4:0] LAST_EDGE     = 5'h0F;

   // reset values
   localparam logic [7:0] CTL_RESET     = 8'h00;
   localparam logic [3:0] SYNC_RESET    = 4'h8; // select idles high

   // synchroniser lanes
   localparam int LN_SCK  = 0;
   localparam int LN_MOSI = 1;
   localparam int LN_MISO = 2;
   localparam int LN_SS   = 3;

   typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} sps_state_e;
endpackage

// ===== hw/sps_port.sv
// serial peripheral port, master or slave, with APB register access
//
// Contract
// - unselected slave keeps its data output floating
// - unselected slave ignores clock and data input, no shifting
// - phase zero slave shows first bit before clock; select fall starts
// - phase zero with select low: data writes blocked, flagged as collision
// - phase one slave takes back-to-back bytes with select held low
// - master seeing select low drops master and enable, sets mode fault
// - master data write starts clock generation and shifting
// - completed byte copied to read buffer; data reads return it
// - data write loads shift register, sent out on mode's output
// - selected slave shifts data in on the master's clock
// - interrupt enable gates interrupt from done or mode fault flags
// - port enable connects pins and mode's output drivers
// - controller select: zero slave, one master; reset gives slave
// - idle clock level sets master's clock level between bytes
// - phase select picks capture and change edges
// - rate select divides clock by 2, 4, 16 or 32 as master
// - rate select ignored in slave mode
// - bytes move most significant bit first on both data lines
// - byte end sets done flag and fills read buffer together
// - enable and master refused while mode fault set, except clearing
//
// The APB register port was decided locally.
`timescale 1ns/100ps
module sps_port (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [9:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // serial pins
   input  wire logic        sck_in,
   output logic             sck_out,
   output logic             sck_oe,
   input  wire logic        mosi_in,
   output logic             mosi_out,
   output logic             mosi_oe,
   input  wire logic        miso_in,
   output logic             miso_out,
   output logic             miso_oe,
   input  wire logic        ss_n,
   // interrupt request
   output logic             irq
);

   // half period in processor clocks for a rate select code
   function automatic logic [4:0] half_of(input logic [1:0] r);
      unique case (r)
         2'b00: return 5'(sps_pkg::DIV_R00 / 2);
         2'b01: return 5'(sps_pkg::DIV_R01 / 2);
         2'b10: return 5'(sps_pkg::DIV_R10 / 2);
         2'b11: return 5'(sps_pkg::DIV_R11 / 2);
      endcase
   endfunction

   // pin synchronisers: three stages, a change counts once stages agree
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic [3:0] sync3;
   logic [3:0] lvl;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1 <= sps_pkg::SYNC_RESET;
         sync2 <= sps_pkg::SYNC_RESET;
         sync3 <= sps_pkg::SYNC_RESET;
         lvl   <= sps_pkg::SYNC_RESET;
      end else begin
         sync1 <= {ss_n, miso_in, mosi_in, sck_in};
         sync2 <= sync1;
         sync3 <= sync2;
         for (int i = 0; i < 4; i++) begin
            if (sync2[i] == sync3[i]) begin
               lvl[i] <= sync3[i];
            end
         end
      end
   end

   // state
   logic                   irq_en, port_en, csel, idle_clock_level, clock_phase_select;
   logic [1:0]             rate;
   logic                   done_flag, write_collision_flag_flag, mode_fault_flag_flag;
   logic                   done_armed, write_collision_flag_armed, mode_fault_flag_armed;
   sps_pkg::sps_state_e    state;
   logic [7:0]             shreg, rbuf;
   logic                   samp;
   logic [3:0]             bit_cnt;
   logic [4:0]             edge_cnt, div_cnt;

   logic                   next_irq_en, next_port_en, next_csel;
   logic                   next_idle_clock_level, next_clock_phase_select;
   logic [1:0]             next_rate;
   logic                   next_done_flag, next_write_collision_flag_flag, next_mode_fault_flag_flag;
   logic                   next_done_armed, next_write_collision_flag_armed;
   logic                   next_mode_fault_flag_armed;
   sps_pkg::sps_state_e    next_state;
   logic [7:0]             next_shreg, next_rbuf;
   logic                   next_samp;
   logic [3:0]             next_bit_cnt;
   logic [4:0]             next_edge_cnt, next_div_cnt;
   logic                   next_sck_out, next_sck_oe, next_mosi_oe;
   logic                   next_miso_oe, next_irq;
   logic [31:0]            next_prdata;
   logic                   next_pready, next_pslverr;

   // decoded events
   logic acc, wr, rd, sel, s_chg, m_tick, lead, trail;
   logic samp_evt, chg_evt, busy, rx_bit;
   logic [7:0] fin_val;
   logic       fin;

   // bus, engine and fault handling in priority order
   always_comb begin
      next_irq_en     = irq_en;
      next_port_en    = port_en;
      next_csel       = csel;
      next_idle_clock_level       = idle_clock_level;
      next_clock_phase_select       = clock_phase_select;
      next_rate       = rate;
      next_done_flag  = done_flag;
      next_write_collision_flag_flag  = write_collision_flag_flag;
      next_mode_fault_flag_flag  = mode_fault_flag_flag;
      next_done_armed = done_armed;
      next_write_collision_flag_armed = write_collision_flag_armed;
      next_mode_fault_flag_armed = mode_fault_flag_armed;
      next_state      = state;
      next_shreg      = shreg;
      next_rbuf       = rbuf;
      next_samp       = samp;
      next_bit_cnt    = bit_cnt;
      next_edge_cnt   = edge_cnt;
      next_div_cnt    = div_cnt;
      fin             = 1'b0;
      fin_val         = shreg;

      acc = psel && penable && pready;
      wr  = acc && pwrite;
      rd  = acc && !pwrite;
      sel = port_en && !csel && !lvl[sps_pkg::LN_SS];
      // slave sees a settled clock change only while selected
      s_chg = sel && (sync2[sps_pkg::LN_SCK] == sync3[sps_pkg::LN_SCK])
              && (sync3[sps_pkg::LN_SCK] != lvl[sps_pkg::LN_SCK]);
      m_tick = csel && (state == sps_pkg::ST_RUN)
               && (div_cnt == half_of(rate) - 5'h01);
      lead  = m_tick ? !edge_cnt[0]
                     : (s_chg && (sync3[sps_pkg::LN_SCK] != idle_clock_level));
      trail = m_tick ? edge_cnt[0]
                     : (s_chg && (sync3[sps_pkg::LN_SCK] == idle_clock_level));
      samp_evt = clock_phase_select ? trail : lead;
      chg_evt  = clock_phase_select ? lead : trail;
      rx_bit   = csel ? lvl[sps_pkg::LN_MISO] : lvl[sps_pkg::LN_MOSI];
      // phase zero slave is frozen from select fall
      busy = (state == sps_pkg::ST_RUN) || (sel && (!clock_phase_select
             || bit_cnt != 4'h0 || lvl[sps_pkg::LN_SCK] != idle_clock_level));

      // control register write; fault blocks enable and master bits
      if (wr && paddr == sps_pkg::ADDR_CONTROL) begin
         next_irq_en = pwdata[sps_pkg::CTL_IRQ_EN];
         next_idle_clock_level   = pwdata[sps_pkg::CTL_IDLE_CLOCK_LEVEL];
         next_clock_phase_select   = pwdata[sps_pkg::CTL_CLOCK_PHASE_SELECT];
         next_rate   = pwdata[sps_pkg::CTL_RATE_HI:sps_pkg::CTL_RATE_LO];
         if (!mode_fault_flag_flag || mode_fault_flag_armed) begin
            next_port_en = pwdata[sps_pkg::CTL_PORT_EN];
            next_csel    = pwdata[sps_pkg::CTL_CSEL];
         end else begin
            next_port_en = 1'b0;
            next_csel    = 1'b0;
         end
         if (mode_fault_flag_armed) begin
            next_mode_fault_flag_flag  = 1'b0;
            next_mode_fault_flag_armed = 1'b0;
         end
      end

      // status read arms the clearing sequences
      if (rd && paddr == sps_pkg::ADDR_STATUS) begin
         next_done_armed = done_flag;
         next_write_collision_flag_armed = write_collision_flag_flag;
         next_mode_fault_flag_armed = mode_fault_flag_flag;
      end

      // data read clears armed done and collision flags
      if (rd && paddr == sps_pkg::ADDR_DATA) begin
         if (done_armed) begin
            next_done_flag = 1'b0;
         end
         if (write_collision_flag_armed) begin
            next_write_collision_flag_flag = 1'b0;
         end
         next_done_armed = 1'b0;
         next_write_collision_flag_armed = 1'b0;
      end

      // data write: inhibited while done is unread, collides when busy
      if (wr && paddr == sps_pkg::ADDR_DATA) begin
         if (done_armed) begin
            next_done_flag = 1'b0;
         end
         if (write_collision_flag_armed && done_flag) begin
            next_write_collision_flag_flag = 1'b0;
         end
         next_done_armed = 1'b0;
         next_write_collision_flag_armed = 1'b0;
         if (done_flag && !done_armed) begin
            next_done_armed = 1'b0; // dropped quietly
         end else if (busy) begin
            next_write_collision_flag_flag = 1'b1;
         end else begin
            next_shreg = pwdata[7:0];
            next_bit_cnt = 4'h0;
            if (csel && port_en) begin
               next_state    = sps_pkg::ST_RUN;
               next_div_cnt  = 5'h00;
               next_edge_cnt = 5'h00;
            end
         end
      end

      // master clock divider and edge count
      if (state == sps_pkg::ST_RUN) begin
         next_div_cnt = m_tick ? 5'h00 : div_cnt + 5'h01;
         if (m_tick) begin
            next_edge_cnt = edge_cnt + 5'h01;
            if (edge_cnt == sps_pkg::LAST_EDGE) begin
               next_state = sps_pkg::ST_IDLE;
            end
         end
      end

      // leaving master mode mid byte abandons it instead of hanging busy
      if (!csel || !port_en) begin
         next_state = sps_pkg::ST_IDLE;
      end

      // capture edge: phase one ends the byte on its eighth capture
      if (samp_evt) begin
         next_samp    = rx_bit;
         next_bit_cnt = bit_cnt + 4'h1;
         if (clock_phase_select && bit_cnt == sps_pkg::BITS_PER_BYTE - 4'h1) begin
            fin     = 1'b1;
            fin_val = {shreg[6:0], rx_bit};
         end
      end

      // change edge: shift left so the msb leaves first
      if (chg_evt && bit_cnt != 4'h0) begin
         next_shreg = {shreg[6:0], samp};
         if (!clock_phase_select && bit_cnt == sps_pkg::BITS_PER_BYTE) begin
            fin     = 1'b1;
            fin_val = {shreg[6:0], samp};
         end
      end

      // byte complete: buffer and flag in the same cycle
      if (fin) begin
         next_shreg     = fin_val;
         next_rbuf      = fin_val;
         next_done_flag = 1'b1;
         next_bit_cnt   = 4'h0;
      end

      // deselected slave drops any partial byte
      if (!csel && !sel) begin
         next_bit_cnt = 4'h0;
      end

      // mode fault wins over any control write this cycle
      if (csel && !lvl[sps_pkg::LN_SS]) begin
         next_mode_fault_flag_flag = 1'b1;
         next_port_en   = 1'b0;
         next_csel      = 1'b0;
         next_state     = sps_pkg::ST_IDLE;
         next_bit_cnt   = 4'h0;
      end

      // pin drivers follow mode and enable
      next_sck_out = (next_state == sps_pkg::ST_RUN && m_tick) ? !sck_out
                   : (next_state == sps_pkg::ST_RUN) ? sck_out
                   : next_idle_clock_level;
      next_sck_oe  = next_port_en && next_csel;
      next_mosi_oe = next_port_en && next_csel;
      next_miso_oe = next_port_en && !next_csel
                     && !lvl[sps_pkg::LN_SS];
      next_irq     = next_irq_en && (next_done_flag || next_mode_fault_flag_flag);

      // register read mux, answered one cycle into the access phase
      next_pready  = psel && penable && !pready;
      next_pslverr = 1'b0;
      next_prdata  = prdata;
      if (psel && penable && !pready) begin
         next_prdata = 32'h0000_0000;
         unique case (paddr)
            sps_pkg::ADDR_CONTROL: begin
               next_prdata[sps_pkg::CTL_IRQ_EN]  = irq_en;
               next_prdata[sps_pkg::CTL_PORT_EN] = port_en;
               next_prdata[sps_pkg::CTL_CSEL]    = csel;
               next_prdata[sps_pkg::CTL_IDLE_CLOCK_LEVEL]    = idle_clock_level;
               next_prdata[sps_pkg::CTL_CLOCK_PHASE_SELECT]    = clock_phase_select;
               next_prdata[sps_pkg::CTL_RATE_HI:sps_pkg::CTL_RATE_LO] = rate;
            end
            sps_pkg::ADDR_STATUS: begin
               next_prdata[sps_pkg::STS_DONE] = done_flag;
               next_prdata[sps_pkg::STS_WRITE_COLLISION_FLAG] = write_collision_flag_flag;
               next_prdata[sps_pkg::STS_MODE_FAULT_FLAG] = mode_fault_flag_flag;
            end
            sps_pkg::ADDR_DATA: next_prdata[7:0] = rbuf;
            default: next_pslverr = 1'b1;
         endcase
      end
   end

   // register all state; outputs are flops
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_en     <= sps_pkg::CTL_RESET[sps_pkg::CTL_IRQ_EN];
         port_en    <= sps_pkg::CTL_RESET[sps_pkg::CTL_PORT_EN];
         csel       <= sps_pkg::CTL_RESET[sps_pkg::CTL_CSEL];
         idle_clock_level       <= sps_pkg::CTL_RESET[sps_pkg::CTL_IDLE_CLOCK_LEVEL];
         clock_phase_select       <= sps_pkg::CTL_RESET[sps_pkg::CTL_CLOCK_PHASE_SELECT];
         rate       <= sps_pkg::CTL_RESET[1:0];
         done_flag  <= 1'b0;
         write_collision_flag_flag  <= 1'b0;
         mode_fault_flag_flag  <= 1'b0;
         done_armed <= 1'b0;
         write_collision_flag_armed <= 1'b0;
         mode_fault_flag_armed <= 1'b0;
         state      <= sps_pkg::ST_IDLE;
         shreg      <= 8'h00;
         rbuf       <= 8'h00;
         samp       <= 1'b0;
         bit_cnt    <= 4'h0;
         edge_cnt   <= 5'h00;
         div_cnt    <= 5'h00;
         sck_out    <= 1'b0;
         sck_oe     <= 1'b0;
         mosi_out   <= 1'b0;
         mosi_oe    <= 1'b0;
         miso_out   <= 1'b0;
         miso_oe    <= 1'b0;
         irq        <= 1'b0;
         prdata     <= 32'h0000_0000;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
      end else begin
         irq_en     <= next_irq_en;
         port_en    <= next_port_en;
         csel       <= next_csel;
         idle_clock_level       <= next_idle_clock_level;
         clock_phase_select       <= next_clock_phase_select;
         rate       <= next_rate;
         done_flag  <= next_done_flag;
         write_collision_flag_flag  <= next_write_collision_flag_flag;
         mode_fault_flag_flag  <= next_mode_fault_flag_flag;
         done_armed <= next_done_armed;
         write_collision_flag_armed <= next_write_collision_flag_armed;
         mode_fault_flag_armed <= next_mode_fault_flag_armed;
         state      <= next_state;
         shreg      <= next_shreg;
         rbuf       <= next_rbuf;
         samp       <= next_samp;
         bit_cnt    <= next_bit_cnt;
         edge_cnt   <= next_edge_cnt;
         div_cnt    <= next_div_cnt;
         sck_out    <= next_sck_out;
         sck_oe     <= next_sck_oe;
         mosi_out   <= next_shreg[7];
         mosi_oe    <= next_mosi_oe;
         miso_out   <= next_shreg[7];
         miso_oe    <= next_miso_oe;
         irq        <= next_irq;
         prdata     <= next_prdata;
         pready     <= next_pready;
         pslverr    <= next_pslverr;
      end
   end

   // helper: cycles since the master clock last toggled
   logic [4:0] gap;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         gap <= 5'h00;
      end else if (state != sps_pkg::ST_RUN || next_sck_out != sck_out) begin
         gap <= 5'h00;
      end else begin
         gap <= gap + 5'h01;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_miso_float_unsel: assert property (
      (lvl[sps_pkg::LN_SS] && !csel) |=> !miso_oe)
      else $error("miso driven while slave deselected");

   a_slave_ignore_clk: assert property (
      (!csel && lvl[sps_pkg::LN_SS]) |=> (bit_cnt == 4'h0)
         && !$rose(done_flag))
      else $error("deselected slave progressed");

   a_write_collision: assert property (
      (wr && paddr == sps_pkg::ADDR_DATA && sel && !clock_phase_select
         && !(done_flag && !done_armed)) |=> write_collision_flag_flag && $stable(shreg))
      else $error("phase zero write not blocked");

   a_mode_fault_drop: assert property (
      (csel && !lvl[sps_pkg::LN_SS]) |=> mode_fault_flag_flag && !csel && !port_en
         ##1 !sck_oe && !mosi_oe)
      else $error("mode fault did not drop master");

   a_done_buffer_fill: assert property (
      $rose(done_flag) |-> (rbuf == shreg) && (bit_cnt == 4'h0))
      else $error("read buffer not filled with done");

   a_irq_gate_done: assert property (
      ($rose(done_flag) && irq_en) |-> irq)
      else $error("interrupt missing on done");

   a_master_rate_div: assert property (
      ($past(state) == sps_pkg::ST_RUN && $changed(sck_out))
         |-> $past(gap) == half_of(rate) - 5'h01)
      else $error("master clock half period wrong");

   a_bit5_reads_zero: assert property (
      (pready && !pwrite && paddr == sps_pkg::ADDR_CONTROL) |-> !prdata[5])
      else $error("control bit five not zero");

   c_master_byte: cover property (
      csel && $rose(done_flag));
   c_slave_byte: cover property (
      !csel && $rose(done_flag));
   c_mode_fault: cover property ($rose(mode_fault_flag_flag));
   c_collision: cover property ($rose(write_collision_flag_flag));

endmodule

// ===== verif/sps_peer.sv
// behavioural serial peer answering the port while it runs as master
`timescale 1ns/100ps
module sps_peer (
   // link pins
   input  wire logic       sel,
   input  wire logic       sck,
   input  wire logic       mosi,
   output logic            miso,
   // mode and payload
   input  wire logic       idle_clock_level,
   input  wire logic       clock_phase_select,
   input  wire logic [7:0] tx,
   output logic      [7:0] rx
);
   int   cnt;
   int   idx;
   logic lastv;
   logic sel_d;
   logic sck_d;
   // known start
   initial begin
      cnt = 0;
      rx = 8'h00;
      lastv = 1'h0;
      sel_d = 1'h0;
      sck_d = 1'h0;
   end
   // one process owns the count: restart on select, else track edges;
   // leading edge leaves idle level, phase picks capture or shift
   always @(sck or sel) begin
      if (sel && !sel_d) begin
         cnt = 0;
      end else if (sck !== sck_d) begin
         lastv = miso;
         if (sel && ((sck !== idle_clock_level) ^ clock_phase_select)) begin
            rx = {rx[6:0], mosi};
         end else if (sel) begin
            cnt = cnt + 1;
         end
      end
      sel_d = sel;
      sck_d = sck;
   end
   // released line shows the inverse, so a stale bit never passes
   always @* begin
      idx = clock_phase_select ? 8 - cnt : 7 - cnt;
      if (sel && idx >= 0 && idx < 8) begin
         miso = tx[idx];
      end else begin
         miso = ~lastv;
      end
   end
endmodule

// ===== verif/tb_sps_port.sv
// self-checking bench: port as master against a peer, then as slave
`timescale 1ns/100ps
module tb_sps_port;
   localparam logic [9:0] CT = sps_pkg::ADDR_CONTROL;
   localparam logic [9:0] SR = sps_pkg::ADDR_STATUS;
   localparam logic [9:0] DR = sps_pkg::ADDR_DATA;
   logic        ref_clk = 1'h0;
   logic        rst     = 1'h1;
   logic        psel    = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite  = 1'h0;
   logic [9:0]  paddr   = 10'h000;
   logic [31:0] pwdata  = 32'h0;
   logic        ss_n    = 1'h1;
   logic        tb_sck  = 1'h0;
   logic        tb_mosi = 1'h0;
   logic        p_sel   = 1'h0;
   logic        p_idle_clock_level  = 1'h0;
   logic        p_clock_phase_select  = 1'h0;
   logic [7:0]  p_tx    = 8'h00;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sck_out;
   logic        sck_oe;
   logic        mosi_out;
   logic        mosi_oe;
   logic        miso_out;
   logic        miso_oe;
   logic        irq;
   logic [7:0]  p_rx;
   logic        p_miso;
   logic [31:0] rd;
   logic        er;
   logic [31:0] seed;
   logic [7:0]  ctl;
   logic [7:0]  st;
   logic [7:0]  mb;
   logic [7:0]  cap;
   logic        ph;
   int          h;
   int          num_errors  = 0;
   int          check_count = 0;
   // wire levels worked out from the port's output enables
   wire logic   sck_w  = sck_oe ? sck_out : tb_sck;
   wire logic   mosi_w = mosi_oe ? mosi_out : tb_mosi;
   wire logic   miso_w = miso_oe ? miso_out : p_miso;

   always #2.5 ref_clk = ~ref_clk;

   sps_port sps_port_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_in(sck_w),
      .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w),
      .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
      .miso_out(miso_out), .miso_oe(miso_oe), .ss_n(ss_n), .irq(irq));
   sps_peer sps_peer_inst (.sel(p_sel), .sck(sck_w), .mosi(mosi_w),
      .miso(p_miso), .idle_clock_level(p_idle_clock_level), .clock_phase_select(p_clock_phase_select), .tx(p_tx), .rx(p_rx));

   // verdict and end of run, also reached by any spent wait
   task complete_run;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task tmo;
      num_errors++;
      complete_run();
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s exp %h seen %h", nm, e, g);
      end
   endtask
   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function int exp_half(input logic [1:0] r);
      case (r)
         2'h0: exp_half = sps_pkg::DIV_R00 / 2;
         2'h1: exp_half = sps_pkg::DIV_R01 / 2;
         2'h2: exp_half = sps_pkg::DIV_R10 / 2;
         default: exp_half = sps_pkg::DIV_R11 / 2;
      endcase
   endfunction
   task wait_cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // apb transfer; request held until pready is sampled high
   task apb(input logic w, input logic [9:0] a, input logic [7:0] d);
      int n;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge ref_clk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (pready !== 1'h1) tmo();
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge ref_clk);
   endtask
   task poll;
      int n;
      n = 0;
      do begin
         apb(1'h0, SR, 8'h00);
         n++;
      end while (rd[7] !== 1'h1 && n < 400);
      if (rd[7] !== 1'h1) tmo();
   endtask
   task wait_chg(output int c);
      logic v;
      c = 0;
      v = sck_out;
      while (sck_out === v && c < 200) begin
         @(posedge ref_clk);
         c++;
      end
      if (sck_out === v) tmo();
   endtask
   // bench as master of a slave port; p sets phase and idle level,
   // each clock level lasts 6 cycles
   task slave_byte(input logic [7:0] m, input logic p, output logic [7:0] c);
      for (int i = 7; i >= 0; i--) begin
         if (!p) tb_mosi <= m[i];
         wait_cyc(6);
         tb_sck <= ~p;
         if (p) tb_mosi <= m[i];
         else c[i] = miso_w;
         wait_cyc(6);
         tb_sck <= p;
         if (p) c[i] = miso_w;
      end
      wait_cyc(6);
   endtask

   initial begin
      seed = 32'h000134CE;
      wait_cyc(4);
      rst <= 1'h0;
      @(posedge ref_clk);
      apb(1'h0, CT, 8'h00);
      chk("ctl", 32'h0, rd);
      apb(1'h1, CT, 8'hFF);
      apb(1'h0, CT, 8'h00);
      chk("ctl", 32'hDF, rd);
      apb(1'h0, 10'h3FC, 8'h00);
      chk("err", 32'h1, 32'(er));
      $display("test regs done");
      // master transfers at every rate; ss_n stays high meanwhile
      for (int k = 0; k < 8; k++) begin
         repeat (9) seed = lfsr(seed);
         ctl = {seed[0], 3'h5, seed[1], seed[2], 2'(k)};
         p_idle_clock_level <= seed[1];
         p_clock_phase_select <= seed[2];
         p_tx <= seed[15:8];
         apb(1'h1, CT, ctl);
         wait_cyc(2);
         chk("idle", 32'(ctl[3]), 32'(sck_out));
         chk("oe", 32'h3, {30'h0, sck_oe, mosi_oe});
         p_sel <= 1'h1;
         apb(1'h1, DR, seed[23:16]);
         apb(1'h1, DR, ~seed[23:16]);
         wait_chg(h);
         wait_chg(h);
         chk("half", 32'(exp_half(ctl[1:0])), 32'(h));
         poll();
         chk("sts", 32'hC0, rd);
         chk("irq", 32'(ctl[7]), 32'(irq));
         chk("peer", 32'(seed[23:16]), 32'(p_rx));
         apb(1'h0, DR, 8'h00);
         if (ctl[1]) chk("rx", 32'(seed[15:8]), rd);
         apb(1'h0, SR, 8'h00);
         chk("clr", 32'h0, rd);
         p_sel <= 1'h0;
         $display("test master %0d done", k);
      end
      // a second master pulls select low
      apb(1'h1, CT, 8'hD0);
      ss_n <= 1'h0;
      wait_cyc(8);
      chk("irq", 32'h1, 32'(irq));
      ss_n <= 1'h1;
      wait_cyc(8);
      chk("oe", 32'h0, {30'h0, sck_oe, mosi_oe});
      apb(1'h0, CT, 8'h00);
      chk("ctl", 32'h80, rd);
      apb(1'h1, CT, 8'h50);
      apb(1'h0, CT, 8'h00);
      chk("ctl", 32'h0, rd);
      apb(1'h0, SR, 8'h00);
      chk("sts", 32'h10, rd);
      apb(1'h1, CT, 8'h00);
      apb(1'h0, SR, 8'h00);
      chk("sts", 32'h0, rd);
      $display("test fault done");
      // slave: unselected first, then both phases
      apb(1'h1, CT, 8'h40);
      chk("oe", 32'h0, 32'(miso_oe));
      slave_byte(8'h3C, 1'h0, cap);
      apb(1'h0, SR, 8'h00);
      chk("sts", 32'h0, rd);
      for (int p = 0; p < 2; p++) begin
         ph = p[0];
         apb(1'h1, CT, {4'h4, ph, ph, 2'h0});
         tb_sck <= ph;
         for (int b = 0; b < 2; b++) begin
            repeat (9) seed = lfsr(seed);
            st = seed[7:0];
            mb = seed[15:8];
            apb(1'h1, DR, st);
            ss_n <= 1'h0;
            wait_cyc(6);
            chk("oe", 32'h1, 32'(miso_oe));
            if (!ph) apb(1'h1, DR, ~st);
            slave_byte(mb, ph, cap);
            if (!ph) ss_n <= 1'h1;
            poll();
            chk("sts", ph ? 32'h80 : 32'hC0, rd);
            apb(1'h0, DR, 8'h00);
            chk("rx", 32'(mb), rd);
            chk("tx", 32'(st), 32'(cap));
         end
         ss_n <= 1'h1;
         wait_cyc(6);
         $display("test slave %0d done", p);
      end
      complete_run();
   end
endmodule
